// ---- hdl/chgreg_pkg.sv ----
package chgreg_pkg;

	// register indices on the serial register port
	localparam logic [7:0] ADDR_KEY = 8'h10;
	localparam logic [7:0] ADDR_FLOAT = 8'h15;
	localparam logic [7:0] ADDR_TIMER = 8'h16;
	localparam logic [7:0] ADDR_BETA = 8'h17;
	localparam logic [7:0] ADDR_STAT0 = 8'h18;
	localparam logic [7:0] ADDR_STAT1 = 8'h19;
	localparam logic [7:0] ADDR_STAT2 = 8'h1a;
	localparam logic [7:0] ADDR_STAT3 = 8'h1b;
	localparam logic [7:0] ADDR_REGPG = 8'h20;

	// write key
	localparam int KEY_LSB = 3;
	localparam logic [4:0] KEY_UNLOCK = 5'h15;
	localparam logic [7:0] KEY_RESET = 8'h03;

	// float voltage / recharge register
	localparam int RESTART_BIT = 6;
	localparam int FLOAT_LSB = 0;
	localparam logic [7:0] FLOAT_RESET = 8'h1e;
	localparam logic [5:0] FLOAT_SAT_CODE = 6'h32;
	localparam logic [12:0] FLOAT_BASE_MV = 13'd3600;
	localparam logic [12:0] FLOAT_STEP_MV = 13'd20;
	localparam logic [12:0] FLOAT_MAX_MV = 13'd4600;
	localparam logic [7:0] RESTART_LO_MV = 8'd140;
	localparam logic [7:0] RESTART_HI_MV = 8'd240;

	// timer / thermistor bias register
	localparam int BIAS_BIT = 7;
	localparam int DOUBLE_BIT = 6;
	localparam int FAST_LSB = 4;
	localparam int PREQ_LSB = 2;
	localparam int TOPOFF_LSB = 0;
	localparam logic [7:0] TIMER_RESET = 8'h95;
	localparam logic [6:0] BIAS_LO_UA = 7'd5;
	localparam logic [6:0] BIAS_HI_UA = 7'd50;
	localparam logic [6:0] BIAS_LO_KOHM = 7'd100;
	localparam logic [6:0] BIAS_HI_KOHM = 7'd10;
	localparam logic [4:0] FAST_BASE_HR = 5'd3;
	localparam logic [4:0] FAST_STEP_HR = 5'd2;
	localparam logic [7:0] PREQ_STEP_MIN = 8'd15;
	localparam logic [7:0] TOPOFF_STEP_DMIN = 8'd64;

	// beta / die thermal register
	localparam int BETA_LSB = 5;
	localparam int DIE_LSB = 0;
	localparam logic [7:0] BETA_RESET = 8'h24;
	localparam logic [7:0] DIE_BASE_C = 8'd80;
	localparam logic [7:0] DIE_STEP_C = 8'd5;

	// status reset and decode values
	localparam logic [2:0] LEVEL_RESET = 3'h7;
	localparam logic [2:0] LEVEL_MISSING = 3'h0;
	localparam logic [2:0] LEVEL_IN_RESET = 3'h7;
	localparam logic [2:0] LEVEL_RSVD = 3'h6;
	localparam logic [2:0] PHASE_RESET = 3'h0;
	localparam logic [1:0] CAUSE_VALID = 2'h3;
	localparam logic [2:0] ZONE_NOMINAL = 3'h0;
	localparam logic [2:0] ZONE_COLD = 3'h1;
	localparam logic [2:0] ZONE_HOT = 3'h4;
	localparam logic [7:0] PG_LOW_PCT = 8'd90;
	localparam logic [7:0] PG_HIGH_PCT = 8'd110;
	localparam int NUM_REGULATORS = 4;

endpackage

// ---- hdl/chgreg_bank.sv ----
`timescale 1ns/10ps
module chgreg_bank #(
	parameter int NREG = chgreg_pkg::NUM_REGULATORS
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// register port from the serial target
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// charger state
	input wire logic battery_present,
	input wire logic [2:0] battery_level_state,
	input wire logic [1:0] input_power_cause,
	input wire logic [7:0] die_temp_c,
	input wire logic thermal_reg_active,
	input wire logic [2:0] charge_phase_state,
	input wire logic [2:0] pack_temp_zone,
	input wire logic [1:0] timeout_cause,
	input wire logic input_current_limited,
	// regulator outputs as percent of nominal
	input wire logic [8*NREG-1:0] reg_out_pct,
	// decoded settings and live status flags
	output logic [12:0] float_mv,
	output logic [12:0] recharge_mv,
	output logic [7:0] recharge_drop_mv,
	output logic thermistor_bias_sel,
	output logic [6:0] thermistor_bias_ua,
	output logic [6:0] thermistor_kohm,
	output logic [4:0] fast_phase_timeout_hr,
	output logic [7:0] precharge_timeout_min,
	output logic [7:0] topoff_duration_dmin,
	output logic [2:0] thermistor_beta_code,
	output logic [7:0] die_temp_limit_c,
	output logic die_temp_loop_active,
	output logic charger_not_suspended,
	output logic status_valid
);

	logic rst_meta;
	logic rst_sync;
	logic [7:0] key_reg;
	logic [7:0] float_reg;
	logic [7:0] timer_reg;
	logic [7:0] beta_reg;
	logic st_present;
	logic [2:0] st_level;
	logic [1:0] st_cause;
	logic st_treg;
	logic st_chip_temp;
	logic [2:0] st_phase;
	logic [2:0] st_zone;
	logic [1:0] st_timeout;
	logic [NREG-1:0] st_pg;
	logic unlocked;
	logic [7:0] stat0;
	logic [7:0] stat1;
	logic [7:0] stat2;
	logic [7:0] stat3;
	logic [7:0] regpg;
	logic [7:0] next_rdata;
	logic [5:0] float_code;
	logic [12:0] next_float_mv;
	logic [7:0] next_drop_mv;
	logic [4:0] next_fast_hr;
	logic [7:0] next_preq_min;
	logic [7:0] next_limit_c;
	logic [NREG-1:0] next_pg;
	logic [NREG-1:0] pg_order;

	// async assert, sync release
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	assign unlocked = key_reg[chgreg_pkg::KEY_LSB +: 5] ==
		chgreg_pkg::KEY_UNLOCK;

	// key register itself is never locked, else it could not be opened
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			key_reg <= chgreg_pkg::KEY_RESET;
		end else if (reg_wr && reg_addr == chgreg_pkg::ADDR_KEY) begin
			key_reg <= reg_wdata;
		end
	end

	// reserved rw bits are stored but steer nothing
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			float_reg <= chgreg_pkg::FLOAT_RESET;
		end else if (reg_wr && unlocked &&
			reg_addr == chgreg_pkg::ADDR_FLOAT) begin
			float_reg <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			timer_reg <= chgreg_pkg::TIMER_RESET;
		end else if (reg_wr && unlocked &&
			reg_addr == chgreg_pkg::ADDR_TIMER) begin
			timer_reg <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			beta_reg <= chgreg_pkg::BETA_RESET;
		end else if (reg_wr && reg_addr == chgreg_pkg::ADDR_BETA) begin
			beta_reg <= reg_wdata;
		end
	end

	// settings decode
	assign float_code = float_reg[chgreg_pkg::FLOAT_LSB +: 6];

	always_comb begin
		if (float_code >= chgreg_pkg::FLOAT_SAT_CODE) begin
			next_float_mv = chgreg_pkg::FLOAT_MAX_MV;
		end else begin
			next_float_mv = 13'(chgreg_pkg::FLOAT_BASE_MV +
				chgreg_pkg::FLOAT_STEP_MV * {7'h00, float_code});
		end
		if (float_reg[chgreg_pkg::RESTART_BIT]) begin
			next_drop_mv = chgreg_pkg::RESTART_HI_MV;
		end else begin
			next_drop_mv = chgreg_pkg::RESTART_LO_MV;
		end
		next_fast_hr = 5'(chgreg_pkg::FAST_BASE_HR + chgreg_pkg::FAST_STEP_HR *
			{3'h0, timer_reg[chgreg_pkg::FAST_LSB +: 2]});
		next_preq_min = 8'(chgreg_pkg::PREQ_STEP_MIN *
			({6'h00, timer_reg[chgreg_pkg::PREQ_LSB +: 2]} + 8'h01));
		if (timer_reg[chgreg_pkg::DOUBLE_BIT]) begin
			next_fast_hr = 5'(next_fast_hr << 1);
			next_preq_min = 8'(next_preq_min << 1);
		end
		next_limit_c = 8'(chgreg_pkg::DIE_BASE_C + chgreg_pkg::DIE_STEP_C *
			{5'h00, beta_reg[chgreg_pkg::DIE_LSB +: 3]});
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			float_mv <= chgreg_pkg::FLOAT_BASE_MV;
			recharge_mv <= 13'h0000;
			recharge_drop_mv <= chgreg_pkg::RESTART_LO_MV;
			fast_phase_timeout_hr <= 5'h00;
			precharge_timeout_min <= 8'h00;
			topoff_duration_dmin <= 8'h00;
			die_temp_limit_c <= chgreg_pkg::DIE_BASE_C;
			thermistor_beta_code <= 3'h0;
		end else begin
			float_mv <= next_float_mv;
			recharge_mv <= 13'(next_float_mv - {5'h00, next_drop_mv});
			recharge_drop_mv <= next_drop_mv;
			fast_phase_timeout_hr <= next_fast_hr;
			precharge_timeout_min <= next_preq_min;
			topoff_duration_dmin <= 8'(chgreg_pkg::TOPOFF_STEP_DMIN *
				{6'h00, timer_reg[chgreg_pkg::TOPOFF_LSB +: 2]});
			die_temp_limit_c <= next_limit_c;
			thermistor_beta_code <= beta_reg[chgreg_pkg::BETA_LSB +: 3];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			thermistor_bias_sel <= 1'b1;
			thermistor_bias_ua <= chgreg_pkg::BIAS_HI_UA;
			thermistor_kohm <= chgreg_pkg::BIAS_HI_KOHM;
		end else begin
			thermistor_bias_sel <= timer_reg[chgreg_pkg::BIAS_BIT];
			if (timer_reg[chgreg_pkg::BIAS_BIT]) begin
				thermistor_bias_ua <= chgreg_pkg::BIAS_HI_UA;
				thermistor_kohm <= chgreg_pkg::BIAS_HI_KOHM;
			end else begin
				thermistor_bias_ua <= chgreg_pkg::BIAS_LO_UA;
				thermistor_kohm <= chgreg_pkg::BIAS_LO_KOHM;
			end
		end
	end

	// regulator window compare, strict on both ends
	for (genvar i = 0; i < NREG; i++) begin : g_pg
		assign next_pg[i] = reg_out_pct[8*i +: 8] > chgreg_pkg::PG_LOW_PCT &&
			reg_out_pct[8*i +: 8] < chgreg_pkg::PG_HIGH_PCT;
		// core buck lands in bit 7, so regulator 0 goes to the top
		assign pg_order[NREG-1-i] = st_pg[i];
	end

	// status snapshot, one cycle behind the charger state
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			st_present <= 1'b0;
			st_level <= chgreg_pkg::LEVEL_RESET;
			st_cause <= 2'h0;
			st_treg <= 1'b0;
			st_chip_temp <= 1'b0;
			st_phase <= chgreg_pkg::PHASE_RESET;
			st_zone <= chgreg_pkg::ZONE_NOMINAL;
			st_timeout <= 2'h0;
			st_pg <= '0;
		end else begin
			st_present <= battery_present;
			st_level <= battery_level_state;
			st_cause <= input_power_cause;
			st_treg <= die_temp_c > next_limit_c;
			st_chip_temp <= thermal_reg_active;
			st_phase <= charge_phase_state;
			st_zone <= pack_temp_zone;
			st_timeout <= timeout_cause;
			st_pg <= next_pg;
		end
	end

	// derived flags read live from the snapshot
	assign stat0 = {st_present,
		st_level != chgreg_pkg::LEVEL_MISSING &&
		st_level != chgreg_pkg::LEVEL_IN_RESET &&
		st_level != chgreg_pkg::LEVEL_RSVD,
		st_cause == chgreg_pkg::CAUSE_VALID,
		!(st_zone == chgreg_pkg::ZONE_COLD || st_zone == chgreg_pkg::ZONE_HOT ||
		st_timeout != 2'h0),
		4'h0};
	assign stat1 = {st_cause, 1'b0, st_treg, 4'h0};
	assign stat2 = {1'b0, st_level, 1'b0, st_phase};
	assign stat3 = {st_zone != chgreg_pkg::ZONE_NOMINAL, st_zone, 1'b0,
		st_chip_temp, st_timeout};
	assign regpg = 8'({pg_order, 4'h0});

	// read mux; status offsets ignore writes since nothing stores them
	always_comb begin
		unique case (reg_addr)
			chgreg_pkg::ADDR_KEY: next_rdata = key_reg;
			chgreg_pkg::ADDR_FLOAT: next_rdata = float_reg;
			chgreg_pkg::ADDR_TIMER: next_rdata = timer_reg;
			chgreg_pkg::ADDR_BETA: next_rdata = beta_reg;
			chgreg_pkg::ADDR_STAT0: next_rdata = stat0;
			chgreg_pkg::ADDR_STAT1: next_rdata = stat1;
			chgreg_pkg::ADDR_STAT2: next_rdata = stat2;
			chgreg_pkg::ADDR_STAT3: next_rdata = stat3;
			chgreg_pkg::ADDR_REGPG: next_rdata = regpg;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// live flags; status trusted by the host only without current limit
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			die_temp_loop_active <= 1'b0;
			charger_not_suspended <= 1'b1;
			status_valid <= 1'b0;
		end else begin
			die_temp_loop_active <= st_treg;
			charger_not_suspended <= stat0[4];
			status_valid <= !input_current_limited;
		end
	end

endmodule

// ---- dv/chgreg_monitor.sv ----
`timescale 1ns/10ps
module chgreg_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// inputs
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] die_temp_c,
	input wire logic [2:0] pack_temp_zone,
	input wire logic [1:0] timeout_cause,
	input wire logic input_current_limited,
	// outputs
	input wire logic [12:0] float_mv,
	input wire logic [12:0] recharge_mv,
	input wire logic [7:0] recharge_drop_mv,
	input wire logic thermistor_bias_sel,
	input wire logic [6:0] thermistor_bias_ua,
	input wire logic [4:0] fast_phase_timeout_hr,
	input wire logic [7:0] precharge_timeout_min,
	input wire logic [7:0] die_temp_limit_c,
	input wire logic die_temp_loop_active,
	input wire logic charger_not_suspended,
	input wire logic status_valid
);
	logic [1:0] up_cnt;
	logic rdy;
	// decoded outputs hold reset values until the release flops pass
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			up_cnt <= 2'h0;
		end else if (up_cnt != 2'h3) begin
			up_cnt <= up_cnt + 2'h1;
		end
	end
	assign rdy = (up_cnt == 2'h3);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	recharge_drop_a: assert property (rdy |->
		recharge_drop_mv inside {8'h8c, 8'hf0} &&
		recharge_mv == float_mv - {5'h0, recharge_drop_mv})
		else $error("recharge level wrong");
	float_range_a: assert property (rdy |->
		float_mv inside {[13'he10:13'h11f8]} &&
		(float_mv - 13'he10) % 13'h14 == 13'h0)
		else $error("float level off step");
	bias_current_a: assert property (rdy |->
		thermistor_bias_ua == (thermistor_bias_sel ? 7'h32 : 7'h05))
		else $error("bias current wrong");
	// doubled pre-charge values overlap plain ones, so pair the sets
	timer_double_a: assert property (rdy |->
		(fast_phase_timeout_hr inside {5'h3, 5'h5, 5'h7, 5'h9} &&
		precharge_timeout_min inside {8'hf, 8'h1e, 8'h2d, 8'h3c}) ||
		(fast_phase_timeout_hr inside {5'h6, 5'ha, 5'he, 5'h12} &&
		precharge_timeout_min inside {8'h1e, 8'h3c, 8'h5a, 8'h78}))
		else $error("timers doubled unequally");
	die_limit_a: assert property (rdy |->
		die_temp_limit_c inside {[8'h50:8'h73]} &&
		(die_temp_limit_c - 8'h50) % 8'h05 == 8'h0)
		else $error("die limit off step");
	loop_set_a: assert property (
		(rdy && die_temp_c > die_temp_limit_c) [*3] |-> die_temp_loop_active)
		else $error("die loop flag not set");
	loop_clear_a: assert property (
		(rdy && die_temp_c <= die_temp_limit_c) [*3] |->
		!die_temp_loop_active)
		else $error("die loop flag not clear");
	suspend_flag_a: assert property (
		(rdy && (pack_temp_zone inside {3'h1, 3'h4} ||
		timeout_cause != 2'h0)) [*3] |-> !charger_not_suspended)
		else $error("charger not suspended");
	status_valid_a: assert property (rdy |->
		status_valid == !$past(input_current_limited))
		else $error("status valid wrong");
	cover property (reg_wr && reg_addr == 8'h16);
	cover property (die_temp_loop_active);
	cover property (rdy && !charger_not_suspended);
endmodule

bind chgreg_bank chgreg_monitor i_mon (.*);

// ---- dv/chgreg_host.sv ----
`timescale 1ns/10ps
module chgreg_host (
	// clock
	input wire logic sys_clk,
	// register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines flip so a stale value is never mistaken for data
	task automatic idle();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	// keyed registers need the key written first
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		idle();
	endtask
	// status bytes are only read, except for deliberate misuse
	task automatic rd(input logic [7:0] a, output logic [8:0] q);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		q = {reg_rvalid, reg_rdata};
		idle();
	endtask
endmodule

// ---- dv/chgreg_bank_tb_top.sv ----
`timescale 1ns/10ps
module chgreg_bank_tb_top;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, die_temp_c, recharge_drop_mv;
	logic reg_wr, reg_rd, reg_rvalid, battery_present, thermal_reg_active;
	logic [2:0] battery_level_state, charge_phase_state, pack_temp_zone;
	logic [1:0] input_power_cause, timeout_cause;
	logic input_current_limited, thermistor_bias_sel, status_valid;
	logic [31:0] reg_out_pct;
	logic [12:0] float_mv, recharge_mv, e, d;
	logic [6:0] thermistor_bias_ua, thermistor_kohm;
	logic [4:0] fast_phase_timeout_hr;
	logic [7:0] precharge_timeout_min, topoff_duration_dmin, die_temp_limit_c;
	logic [2:0] thermistor_beta_code, z;
	logic die_temp_loop_active, charger_not_suspended, ns;
	logic [8:0] q;
	logic [3:0] pg;
	logic [7:0] pv [4] = '{8'h5a, 8'h5b, 8'h6d, 8'h6e};
	logic [7:0] fc [4] = '{8'h00, 8'h71, 8'h32, 8'h7f};
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	chgreg_bank i_dut (.*);
	chgreg_host i_host (.*);
	always #5 sys_clk = ~sys_clk;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// a hang costs one mismatch and ends the run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [12:0] s, logic [12:0] x);
		tests_run++;
		if (s !== x) begin
			fail_count++;
			$display("mismatch %0s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		i_host.rd(a, q);
		chk($sformatf("reg %h", a), {4'h0, q}, {5'h1, x});
	endtask
	initial begin
		{battery_present, battery_level_state, input_power_cause} = '0;
		{die_temp_c, thermal_reg_active, charge_phase_state} = '0;
		{pack_temp_zone, timeout_cause, input_current_limited} = '0;
		reg_out_pct = '0;
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (3) @(posedge sys_clk);
		rchk(8'h10, 8'h03);
		rchk(8'h16, 8'h95);
		rchk(8'h17, 8'h24);
		rchk(8'h15, 8'h1e);
		chk("float", float_mv, 13'h1068);
		chk("recharge", recharge_mv, 13'hfdc);
		chk("fast", fast_phase_timeout_hr, 13'h5);
		chk("preq", precharge_timeout_min, 13'h1e);
		chk("topoff", topoff_duration_dmin, 13'h40);
		chk("beta", thermistor_beta_code, 13'h1);
		chk("limit", die_temp_limit_c, 13'h64);
		$display("test reset done");
		i_host.wr(8'h16, 8'h40);
		i_host.wr(8'h10, 8'ha0);
		i_host.wr(8'h16, 8'h40);
		rchk(8'h16, 8'h95);
		i_host.wr(8'h10, 8'ha8);
		for (int i = 0; i < 4; i++) begin
			i_host.wr(8'h16, {2'b10, i[1:0], i[1:0], i[1:0]});
			@(negedge sys_clk);
			chk("fast", fast_phase_timeout_hr, 13'(3 + 2 * i));
			chk("preq", precharge_timeout_min, 13'(15 * i + 15));
			chk("topoff", topoff_duration_dmin, 13'(64 * i));
		end
		i_host.wr(8'h16, 8'h7f);
		@(negedge sys_clk);
		chk("fast", fast_phase_timeout_hr, 13'h12);
		chk("preq", precharge_timeout_min, 13'h78);
		chk("kohm", thermistor_kohm, 13'h64);
		chk("bias_ua", 13'(thermistor_bias_ua), 13'h5);
		chk("bias_sel", 13'(thermistor_bias_sel), 13'h0);
		$display("test timers done");
		foreach (fc[k]) begin
			i_host.wr(8'h15, fc[k]);
			@(negedge sys_clk);
			e = fc[k][5:0] < 6'h32 ? 13'he10 + 13'h14 * fc[k][5:0] : 13'h11f8;
			d = fc[k][6] ? 13'hf0 : 13'h8c;
			chk("float", float_mv, e);
			chk("recharge", recharge_mv, e - d);
			chk("drop", 13'(recharge_drop_mv), d);
		end
		i_host.wr(8'h10, 8'h00);
		i_host.wr(8'h15, 8'h00);
		@(negedge sys_clk);
		chk("float", float_mv, 13'h11f8);
		for (int i = 0; i < 8; i++) begin
			i_host.wr(8'h17, {i[2:0], 2'b00, i[2:0]});
			@(negedge sys_clk);
			chk("beta", thermistor_beta_code, 13'(i));
			chk("limit", die_temp_limit_c, 13'(80 + 5 * i));
		end
		$display("test float done");
		for (int i = 0; i < 8; i++) begin
			z = 3'(i % 5);
			{battery_present, battery_level_state} = {i[0], i[2:0]};
			{input_power_cause, pack_temp_zone} = {i[1:0], z};
			{timeout_cause, charge_phase_state} = {i[2:1], ~i[2:0]};
			{thermal_reg_active, input_current_limited} = i[1:0];
			die_temp_c = 8'(112 + i);
			for (int k = 0; k < 4; k++) begin
				reg_out_pct[8*k +: 8] = pv[(i + k) % 4];
				pg[3 - k] = pv[(i + k) % 4] inside {8'h5b, 8'h6d};
			end
			repeat (3) @(negedge sys_clk);
			ns = !(z == 3'h1 || z == 3'h4 || i[2:1] != 2'h0);
			rchk(8'h18, {i[0], i[2:0] inside {[3'h1:3'h5]},
				i[1:0] == 2'h3, ns, 4'h0});
			rchk(8'h19, {i[1:0], 1'b0, i >= 4, 4'h0});
			rchk(8'h1a, {1'b0, i[2:0], 1'b0, ~i[2:0]});
			rchk(8'h1b, {z != 3'h0, z, 1'b0, i[1], i[2:1]});
			rchk(8'h20, {pg, 4'h0});
			chk("suspend", 13'(charger_not_suspended), 13'(ns));
			chk("loop", 13'(die_temp_loop_active), 13'(i >= 4));
			chk("valid", 13'(status_valid), 13'(!i[0]));
		end
		i_host.wr(8'h1b, 8'hff);
		rchk(8'h1b, 8'ha7);
		rchk(8'h1c, 8'h00);
		$display("test status done");
		print_verdict();
	end
endmodule
